// File: afd_addsub.sv
`timescale 1ns/1ps
`include "afd_consts.svh"

module afd_addsub (
   // operands
   input wire logic [15:0] i_a,
   input wire logic [15:0] i_b,
   input wire logic i_cin,
   input wire logic i_sub,
   input wire logic i_word,
   // results
   output logic [15:0] o_sum,
   output logic o_carry,
   output logic o_nibble_carry,
   output logic o_overflow
);

   logic [16:0] wide;
   logic [8:0] narrow;
   logic [4:0] nib;
   logic sa;
   logic sb;
   logic sr;

   // ----------------------------------------------------------------
   // one unsigned adder serves signed and unsigned data alike
   // ----------------------------------------------------------------
   always_comb begin
      if (i_sub) begin
         wide = {1'b0, i_a} - {1'b0, i_b} - {16'h0000, i_cin};   // [RL4] [RL13] [RL14]
         narrow = {1'b0, i_a[7:0]} - {1'b0, i_b[7:0]} - {8'h00, i_cin};
         nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, i_cin};
      end else begin
         wide = {1'b0, i_a} + {1'b0, i_b} + {16'h0000, i_cin};   // [RL4] [RL12] [RL14]
         narrow = {1'b0, i_a[7:0]} + {1'b0, i_b[7:0]} + {8'h00, i_cin};
         nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
      end
   end

   // ----------------------------------------------------------------
   // width select and signed overflow
   // ----------------------------------------------------------------
   always_comb begin
      if (i_word) begin   // [RL1]
         o_sum = wide[15:0];
         o_carry = wide[16];
         sa = i_a[`AFD_WORD_MSB];
         sb = i_b[`AFD_WORD_MSB];
         sr = wide[`AFD_WORD_MSB];
      end else begin
         o_sum = {8'h00, narrow[7:0]};
         o_carry = narrow[8];
         sa = i_a[`AFD_BYTE_MSB];
         sb = i_b[`AFD_BYTE_MSB];
         sr = narrow[`AFD_BYTE_MSB];
      end
      o_nibble_carry = nib[4];   // [RL15]
      // operand signs equal on add, opposite on subtract, result sign differs
      o_overflow = ((sa ^ sb) == i_sub) && (sr != sa);   // [RL3] [RL19]
   end

endmodule // afd_addsub

// File: afd_consts.svh
`ifndef AFD_CONSTS_SVH
`define AFD_CONSTS_SVH

// ----------------------------------------------------------------
// flag positions inside the six-bit flag vector, and the flag count
// ----------------------------------------------------------------
`define AFD_FLG_CY 0
`define AFD_FLG_PAR 1
`define AFD_FLG_NIB 2
`define AFD_FLG_ZERO 3
`define AFD_FLG_SGN 4
`define AFD_FLG_OVF 5
`define AFD_FLG_CNT 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AFD_FLAGS_RST 6'h00
`define AFD_RESULT_RST 16'h0000

// ----------------------------------------------------------------
// operand widths and sign bits
// ----------------------------------------------------------------
`define AFD_WORD_W 16
`define AFD_BYTE_W 8
`define AFD_WORD_MSB 15
`define AFD_BYTE_MSB 7

// ----------------------------------------------------------------
// decimal adjust constants and the plus/minus one step
// ----------------------------------------------------------------
`define AFD_DIGIT_MAX 4'h9
`define AFD_PACKED_MAX 8'h99
`define AFD_LOW_FIX 8'h06
`define AFD_HIGH_FIX 8'h60
`define AFD_LOW_NIBBLE 8'h0F
`define AFD_DIGIT_BASE 8'h0A
`define AFD_ONE 16'h0001

`endif

// File: afd_datapath.sv
`timescale 1ns/1ps
`include "afd_consts.svh"

// How it works
// RL1: every binary operation works on byte or word operands alike.
// RL2: add, add with carry, plus one, subtract, borrow, minus one, inversion, compare.
// RL3: signed values are two's complement with the top bit as sign.
// RL4: signed add and subtract reuse the one unsigned adder.
// RL5: a packed decimal byte holds two digits, high digit in upper nibble.
// RL6: packed decimal add/subtract is binary, then an adjust fixes the low byte.
// RL7: there is no packed decimal adjust for multiply or divide.
// RL8: the program zeroes the unpacked upper nibble before multiply or divide.
// RL9: unpacked division adjusts the low byte numerator, then divides unsigned.
// RL10: unpacked add and subtract adjusts leave the upper nibble of the result zero.
// RL11: six flags, each changed only by operations that affect it.
// RL12: carry flag is the carry out of the top bit on addition.
// RL13: carry flag is the borrow into the top bit on subtraction.
// RL14: carry-in add and borrow-in subtract use the stored carry flag.
// RL15: nibble carry flag is carry out of or borrow into the low nibble.
// RL16: sign flag copies bit 7 or bit 15 of the result.
// RL17: zero flag is set when the result at its width is all zero.
// RL18: parity flag is set for even ones in the low eight result bits.
// RL19: overflow flag is set when the signed result does not fit.
// RL20: plus one and minus one leave the carry flag alone.
// RL21: inversion sets carry for nonzero operands; most negative value sets overflow.
// RL22: compare subtracts and sets all six flags but writes no result.
// RL23: all flags come from one result and register on the same edge.

module afd_datapath
   import afd_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // operation request
   input wire logic i_op_valid,
   input wire afd_op_t i_op,
   input wire logic i_word,
   input wire logic [15:0] i_dst,
   input wire logic [15:0] i_src,
   // result
   output logic [15:0] o_result,
   output logic o_result_we,
   output logic o_div_error,
   // status flags
   output logic o_carry_flag,
   output logic o_nibble_carry_flag,
   output logic o_sign_flag,
   output logic o_zero_result_flag,
   output logic o_parity_flag,
   output logic o_signed_overflow_flag
);

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   // which flags an operation writes; the others keep their value
   function automatic logic [5:0] flag_mask(input afd_op_t op);
      logic [5:0] m;
      m = 6'h00;
      case (op)
         AFD_OP_ADD, AFD_OP_ADD_CARRY_IN, AFD_OP_SUBTRACT, AFD_OP_SUBTRACT_WITH_BORROW_IN,
         AFD_OP_SIGN_INVERSION, AFD_OP_COMPARE_ONLY: begin
            m = 6'h3F;
         end
         AFD_OP_PLUS_ONE, AFD_OP_MINUS_ONE: begin
            m = 6'h3F;
            m[`AFD_FLG_CY] = 1'b0;   // [RL20]
         end
         AFD_OP_PACKED_ADJ_ADD, AFD_OP_PACKED_ADJ_SUB: begin
            m = 6'h3F;
            m[`AFD_FLG_OVF] = 1'b0;
         end
         AFD_OP_UNPACKED_ADJ_ADD, AFD_OP_UNPACKED_ADJ_SUB: begin
            m[`AFD_FLG_CY] = 1'b1;
            m[`AFD_FLG_NIB] = 1'b1;
         end
         AFD_OP_UNPACKED_ADJ_DIV: begin
            m[`AFD_FLG_PAR] = 1'b1;
            m[`AFD_FLG_ZERO] = 1'b1;
            m[`AFD_FLG_SGN] = 1'b1;
         end
         default: begin
            m = 6'h00;
         end
      endcase
      return m;   // [RL11]
   endfunction

   // true for operations that go through the binary adder
   function automatic logic is_binary(input afd_op_t op);
      return (op <= AFD_OP_COMPARE_ONLY);
   endfunction

   // ----------------------------------------------------------------
   // operand steering into the shared adder
   // ----------------------------------------------------------------
   logic [15:0] add_a;
   logic [15:0] add_b;
   logic add_cin;
   logic add_sub;
   logic [15:0] add_sum;
   logic add_carry;
   logic add_nibble;
   logic add_ovf;

   always_comb begin
      add_a = i_dst;
      add_b = i_src;
      add_cin = 1'b0;
      add_sub = 1'b0;
      case (i_op)   // [RL2]
         AFD_OP_ADD_CARRY_IN: begin
            add_cin = o_carry_flag;   // [RL14]
         end
         AFD_OP_PLUS_ONE: begin
            add_b = `AFD_ONE;
         end
         AFD_OP_SUBTRACT, AFD_OP_COMPARE_ONLY: begin
            add_sub = 1'b1;   // [RL22]
         end
         AFD_OP_SUBTRACT_WITH_BORROW_IN: begin
            add_sub = 1'b1;
            add_cin = o_carry_flag;   // [RL14]
         end
         AFD_OP_MINUS_ONE: begin
            add_sub = 1'b1;
            add_b = `AFD_ONE;
         end
         AFD_OP_SIGN_INVERSION: begin
            // zero minus operand: borrow exactly when nonzero, overflow on most negative
            add_sub = 1'b1;   // [RL21]
            add_a = 16'h0000;
            add_b = i_dst;
         end
         default: begin
            add_sub = 1'b0;
         end
      endcase
   end

   afd_addsub u_addsub (
      .i_a(add_a),
      .i_b(add_b),
      .i_cin(add_cin),
      .i_sub(add_sub),
      .i_word(i_word),
      .o_sum(add_sum),
      .o_carry(add_carry),
      .o_nibble_carry(add_nibble),
      .o_overflow(add_ovf)
   );

   // ----------------------------------------------------------------
   // decimal adjust and byte divide on the accumulator
   // ----------------------------------------------------------------
   logic [7:0] acc_lo;
   logic [7:0] acc_hi;
   logic lo_fix;
   logic hi_fix;
   logic [7:0] step_lo;
   logic [7:0] fold_lo;
   logic [15:0] quot;
   logic [15:0] remd;
   logic div_bad;

   assign acc_lo = i_dst[7:0];
   assign acc_hi = i_dst[15:8];
   assign lo_fix = (acc_lo[3:0] > `AFD_DIGIT_MAX) || o_nibble_carry_flag;   // [RL5]
   assign hi_fix = (acc_lo > `AFD_PACKED_MAX) || o_carry_flag;
   assign fold_lo = 8'({acc_hi, 3'b000}) + 8'({acc_hi, 1'b0}) + acc_lo;
   assign quot = (i_src[7:0] == 8'h00) ? 16'h0000 : i_dst / {8'h00, i_src[7:0]};
   assign remd = (i_src[7:0] == 8'h00) ? 16'h0000 : i_dst % {8'h00, i_src[7:0]};
   assign div_bad = (i_src[7:0] == 8'h00) || (quot[15:8] != 8'h00);

   // ----------------------------------------------------------------
   // next result and flags
   // ----------------------------------------------------------------
   logic [15:0] next_result;
   logic next_carry;
   logic next_nibble;
   logic next_ovf;
   logic next_word;
   logic [5:0] next_flags;
   logic [5:0] cur_flags;

   always_comb begin
      step_lo = acc_lo;
      next_result = add_sum;
      next_carry = add_carry;
      next_nibble = add_nibble;
      next_ovf = add_ovf;
      next_word = i_word;
      case (i_op)
         AFD_OP_PACKED_ADJ_ADD: begin   // [RL6]
            step_lo = lo_fix ? acc_lo + `AFD_LOW_FIX : acc_lo;
            next_result = {acc_hi, hi_fix ? step_lo + `AFD_HIGH_FIX : step_lo};
            next_carry = hi_fix;
            next_nibble = lo_fix;
            next_word = 1'b0;
         end
         AFD_OP_PACKED_ADJ_SUB: begin   // [RL6]
            step_lo = lo_fix ? acc_lo - `AFD_LOW_FIX : acc_lo;
            next_result = {acc_hi, hi_fix ? step_lo - `AFD_HIGH_FIX : step_lo};
            next_carry = hi_fix;
            next_nibble = lo_fix;
            next_word = 1'b0;
         end
         AFD_OP_UNPACKED_ADJ_ADD: begin
            step_lo = lo_fix ? acc_lo + `AFD_LOW_FIX : acc_lo;
            next_result = {lo_fix ? acc_hi + 8'h01 : acc_hi, step_lo & `AFD_LOW_NIBBLE};   // [RL10]
            next_carry = lo_fix;
            next_nibble = lo_fix;
            next_word = 1'b0;
         end
         AFD_OP_UNPACKED_ADJ_SUB: begin
            step_lo = lo_fix ? acc_lo - `AFD_LOW_FIX : acc_lo;
            next_result = {lo_fix ? acc_hi - 8'h01 : acc_hi, step_lo & `AFD_LOW_NIBBLE};   // [RL10]
            next_carry = lo_fix;
            next_nibble = lo_fix;
            next_word = 1'b0;
         end
         AFD_OP_UNPACKED_ADJ_DIV: begin
            // digits folded into a binary numerator ahead of the divide
            next_result = {8'h00, fold_lo};   // [RL9]
            next_word = 1'b0;
         end
         AFD_OP_UNSIGNED_DIV_BYTE: begin
            next_result = {remd[7:0], quot[7:0]};   // [RL9]
            next_word = 1'b0;
         end
         default: begin
            step_lo = acc_lo;
         end
      endcase
      next_flags[`AFD_FLG_CY] = next_carry;
      next_flags[`AFD_FLG_NIB] = next_nibble;
      next_flags[`AFD_FLG_OVF] = next_ovf;
      next_flags[`AFD_FLG_PAR] = ~^next_result[7:0];   // [RL18]
      next_flags[`AFD_FLG_SGN] = next_word ? next_result[`AFD_WORD_MSB]
                                           : next_result[`AFD_BYTE_MSB];   // [RL16]
      next_flags[`AFD_FLG_ZERO] = next_word ? (next_result == 16'h0000)
                                            : (next_result[7:0] == 8'h00);   // [RL17]
   end

   assign cur_flags = {o_signed_overflow_flag, o_sign_flag, o_zero_result_flag,
                       o_nibble_carry_flag, o_parity_flag, o_carry_flag};

   // ----------------------------------------------------------------
   // flag register
   // ----------------------------------------------------------------
   logic [5:0] flag_sel;
   logic [5:0] flags_q;
   assign flag_sel = flag_mask(i_op);

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_q <= `AFD_FLAGS_RST;
      end else if (i_op_valid) begin
         flags_q <= (next_flags & flag_sel) | (cur_flags & ~flag_sel);   // [RL11] [RL23]
      end
   end
   assign o_carry_flag = flags_q[`AFD_FLG_CY];
   assign o_parity_flag = flags_q[`AFD_FLG_PAR];
   assign o_nibble_carry_flag = flags_q[`AFD_FLG_NIB];
   assign o_zero_result_flag = flags_q[`AFD_FLG_ZERO];
   assign o_sign_flag = flags_q[`AFD_FLG_SGN];
   assign o_signed_overflow_flag = flags_q[`AFD_FLG_OVF];

   // ----------------------------------------------------------------
   // result register and write-back strobe
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result <= `AFD_RESULT_RST;
      end else if (i_op_valid) begin
         o_result <= next_result;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result_we <= 1'b0;
         o_div_error <= 1'b0;
      end else begin
         o_result_we <= i_op_valid && (i_op != AFD_OP_COMPARE_ONLY)   // [RL22]
                        && !((i_op == AFD_OP_UNSIGNED_DIV_BYTE) && div_bad)
                        && (i_op <= AFD_OP_UNSIGNED_DIV_BYTE);   // [RL7]
         o_div_error <= i_op_valid && (i_op == AFD_OP_UNSIGNED_DIV_BYTE) && div_bad;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   AST_ADD_WORD_CARRY: assert property ( // [RL12]
      i_op_valid && i_op == AFD_OP_ADD && i_word
      |=> o_carry_flag == (({1'b0, $past(i_dst)} + {1'b0, $past(i_src)}) > 17'h0FFFF))
      else $error("word add carry wrong");
   AST_SUB_BYTE_BORROW: assert property ( // [RL13]
      i_op_valid && i_op == AFD_OP_SUBTRACT && !i_word
      |=> o_carry_flag == ($past(i_dst[7:0]) < $past(i_src[7:0])))
      else $error("byte subtract borrow wrong");
   AST_STEP_KEEPS_CARRY: assert property ( // [RL20]
      i_op_valid && (i_op == AFD_OP_PLUS_ONE || i_op == AFD_OP_MINUS_ONE)
      |=> $stable(o_carry_flag))
      else $error("plus or minus one changed carry");
   AST_INVERSION_CARRY: assert property ( // [RL21]
      i_op_valid && i_op == AFD_OP_SIGN_INVERSION && !i_word
      |=> o_carry_flag == ($past(i_dst[7:0]) != 8'h00)
          && o_signed_overflow_flag == ($past(i_dst[7:0]) == 8'h80))
      else $error("inversion carry or overflow wrong");
   AST_COMPARE_NO_WRITE: assert property ( // [RL22]
      i_op_valid && i_op == AFD_OP_COMPARE_ONLY
      |=> !o_result_we
          && o_zero_result_flag == ($past(i_word) ? o_result == 16'h0000 : o_result[7:0] == 8'h00))
      else $error("compare wrote a result");
   AST_SIGN_COPIES_MSB: assert property ( // [RL16]
      i_op_valid && is_binary(i_op)
      |=> o_sign_flag == ($past(i_word) ? o_result[15] : o_result[7]))
      else $error("sign flag does not match result");
   AST_PARITY_EVEN: assert property ( // [RL18]
      i_op_valid && is_binary(i_op) |=> o_parity_flag == ~^o_result[7:0])
      else $error("parity flag wrong");
   AST_UNPACKED_HIGH_ZERO: assert property ( // [RL10]
      i_op_valid && (i_op == AFD_OP_UNPACKED_ADJ_ADD || i_op == AFD_OP_UNPACKED_ADJ_SUB)
      |=> o_result[7:4] == 4'h0 && o_result_we)
      else $error("unpacked adjust left upper nibble set");
   AST_FLAGS_HOLD_IDLE: assert property ( // [RL23]
      !i_op_valid |=> $stable(flags_q))
      else $error("flags moved without an operation");
   AST_BYTE_ADD_OVERFLOW: assert property ( // [RL19]
      i_op_valid && i_op == AFD_OP_ADD && !i_word
      |=> o_signed_overflow_flag == (($past(i_dst[7]) == $past(i_src[7])) && (o_result[7] != $past(i_dst[7]))))
      else $error("byte add overflow wrong");

endmodule // afd_datapath

// File: afd_pkg.sv
package afd_pkg;

   // ----------------------------------------------------------------
   // operation codes driven by the instruction sequencer
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      AFD_OP_ADD = 4'h0,
      AFD_OP_ADD_CARRY_IN = 4'h1,
      AFD_OP_PLUS_ONE = 4'h2,
      AFD_OP_SUBTRACT = 4'h3,
      AFD_OP_SUBTRACT_WITH_BORROW_IN = 4'h4,
      AFD_OP_MINUS_ONE = 4'h5,
      AFD_OP_SIGN_INVERSION = 4'h6,
      AFD_OP_COMPARE_ONLY = 4'h7,
      AFD_OP_PACKED_ADJ_ADD = 4'h8,
      AFD_OP_PACKED_ADJ_SUB = 4'h9,
      AFD_OP_UNPACKED_ADJ_ADD = 4'hA,
      AFD_OP_UNPACKED_ADJ_SUB = 4'hB,
      AFD_OP_UNPACKED_ADJ_DIV = 4'hC,
      AFD_OP_UNSIGNED_DIV_BYTE = 4'hD
   } afd_op_t;

endpackage

// File: afd_seq_model.sv
`timescale 1ns/1ps

module afd_seq_model
   import afd_pkg::*;
(
   // clock
   input wire logic i_sys_clk,
   // operation request towards the datapath
   output logic o_op_valid,
   output afd_op_t o_op,
   output logic o_word,
   output logic [15:0] o_dst,
   output logic [15:0] o_src
);

   initial begin
      o_op_valid = 1'b0;
      o_op = AFD_OP_ADD;
      o_word = 1'b0;
      o_dst = 16'h0000;
      o_src = 16'h0000;
   end

   // ----------------------------------------------------------------
   // one request per falling edge, held until the next call
   // ----------------------------------------------------------------
   task automatic issue(input afd_op_t op, input logic w, input logic [15:0] d, input logic [15:0] s);
      @(negedge i_sys_clk);
      o_op_valid = 1'b1;
      o_op = op;
      o_word = w;
      o_dst = (op == AFD_OP_UNPACKED_ADJ_DIV) ? (d & 16'h0F0F) : d;
      o_src = s;
   endtask

   // released operands never show their last value
   task automatic idle();
      @(negedge i_sys_clk);
      o_op_valid = 1'b0;
      o_dst = ~o_dst;
      o_src = ~o_src;
   endtask

endmodule // afd_seq_model

// File: tb_top.sv
`timescale 1ns/1ps
`include "afd_consts.svh"

module tb_top
   import afd_pkg::*;
;

   typedef struct packed {
      logic [15:0] res;
      logic chk;
      logic we;
      logic derr;
      logic [5:0] flg;
   } afd_exp_t;

   localparam int B_CY = `AFD_FLG_CY;
   localparam int B_PA = `AFD_FLG_PAR;
   localparam int B_NB = `AFD_FLG_NIB;
   localparam int B_ZR = `AFD_FLG_ZERO;
   localparam int B_SG = `AFD_FLG_SGN;
   localparam int B_OV = `AFD_FLG_OVF;

   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic op_valid;
   afd_op_t op;
   logic word;
   logic [15:0] dst;
   logic [15:0] src;
   logic [15:0] o_result;
   logic o_result_we;
   logic o_div_error;
   logic [5:0] flags_out;
   logic [5:0] model_flags = 6'h00;
   logic seen_valid;
   afd_exp_t exp_q[$];
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;

   always #12.5 i_sys_clk = ~i_sys_clk;

   afd_seq_model u_seq (.i_sys_clk(i_sys_clk), .o_op_valid(op_valid), .o_op(op), .o_word(word),
      .o_dst(dst), .o_src(src));

   afd_datapath u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_op_valid(op_valid), .i_op(op),
      .i_word(word), .i_dst(dst), .i_src(src), .o_result(o_result), .o_result_we(o_result_we),
      .o_div_error(o_div_error), .o_carry_flag(flags_out[B_CY]), .o_nibble_carry_flag(flags_out[B_NB]),
      .o_sign_flag(flags_out[B_SG]), .o_zero_result_flag(flags_out[B_ZR]), .o_parity_flag(flags_out[B_PA]),
      .o_signed_overflow_flag(flags_out[B_OV]));

   // ----------------------------------------------------------------
   // reference behaviour
   // ----------------------------------------------------------------
   function automatic afd_exp_t model(input afd_op_t o, input logic w, input logic [15:0] d,
      input logic [15:0] s, input logic [5:0] f);
      afd_exp_t e;
      logic [15:0] m;
      logic [15:0] a;
      logic [15:0] b;
      logic [16:0] r;
      logic [4:0] n;
      logic [7:0] acc;
      logic [7:0] fix;
      logic sub;
      logic cin;
      logic adj;
      logic cy;
      logic ww;
      m = w ? 16'hFFFF : 16'h00FF;
      a = d & m;
      b = s & m;
      sub = o inside {AFD_OP_SUBTRACT, AFD_OP_SUBTRACT_WITH_BORROW_IN, AFD_OP_MINUS_ONE, AFD_OP_SIGN_INVERSION,
         AFD_OP_COMPARE_ONLY};
      cin = (o inside {AFD_OP_ADD_CARRY_IN, AFD_OP_SUBTRACT_WITH_BORROW_IN}) & f[B_CY];
      if (o inside {AFD_OP_PLUS_ONE, AFD_OP_MINUS_ONE}) begin
         b = 16'h0001;
      end
      if (o == AFD_OP_SIGN_INVERSION) begin
         b = a;
         a = 16'h0000;
      end
      r = sub ? {1'b0, a} - {1'b0, b} - 17'(cin) : {1'b0, a} + {1'b0, b} + 17'(cin);
      n = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin) : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
      e.flg = f;
      e.chk = 1'b1;
      e.we = 1'b1;
      e.derr = 1'b0;
      e.res = r[15:0] & m;
      acc = d[7:0];
      ww = w && (o < AFD_OP_PACKED_ADJ_ADD);
      case (o)
         AFD_OP_ADD, AFD_OP_ADD_CARRY_IN, AFD_OP_PLUS_ONE, AFD_OP_SUBTRACT, AFD_OP_SUBTRACT_WITH_BORROW_IN,
         AFD_OP_MINUS_ONE, AFD_OP_SIGN_INVERSION, AFD_OP_COMPARE_ONLY: begin
            if (!(o inside {AFD_OP_PLUS_ONE, AFD_OP_MINUS_ONE})) begin
               e.flg[B_CY] = w ? r[16] : r[8];
            end
            e.flg[B_NB] = n[4];
            e.flg[B_OV] = ((w ? a[15] ^ b[15] : a[7] ^ b[7]) == sub) && ((w ? e.res[15] ^ a[15] : e.res[7] ^ a[7]));
            e.we = (o != AFD_OP_COMPARE_ONLY);
         end
         AFD_OP_PACKED_ADJ_ADD, AFD_OP_PACKED_ADJ_SUB: begin
            cy = (acc > 8'h99) | f[B_CY];
            adj = (acc[3:0] > 4'h9) | f[B_NB];
            fix = {cy ? 4'h6 : 4'h0, adj ? 4'h6 : 4'h0};
            e.res = {d[15:8], (o == AFD_OP_PACKED_ADJ_ADD) ? acc + fix : acc - fix};
            e.flg[B_CY] = cy;
            e.flg[B_NB] = adj;
         end
         AFD_OP_UNPACKED_ADJ_ADD, AFD_OP_UNPACKED_ADJ_SUB: begin
            adj = (acc[3:0] > 4'h9) | f[B_NB];
            fix = adj ? 8'h06 : 8'h00;
            if (o == AFD_OP_UNPACKED_ADJ_ADD) begin
               e.res = {d[15:8] + {7'h00, adj}, (acc + fix) & 8'h0F};
            end else begin
               e.res = {d[15:8] - {7'h00, adj}, (acc - fix) & 8'h0F};
            end
            e.flg[B_CY] = adj;
            e.flg[B_NB] = adj;
         end
         AFD_OP_UNPACKED_ADJ_DIV: e.res = {8'h00, d[15:8] * 8'h0A + acc};
         AFD_OP_UNSIGNED_DIV_BYTE: begin
            if (s[7:0] == 8'h00 || d / s[7:0] > 16'h00FF) begin
               e.chk = 1'b0;
               e.we = 1'b0;
               e.derr = 1'b1;
            end else begin
               e.res = {8'(d % s[7:0]), 8'(d / s[7:0])};
            end
         end
         default: begin
            e.chk = 1'b0;
            e.we = 1'b0;
         end
      endcase
      if (o inside {[AFD_OP_ADD:AFD_OP_PACKED_ADJ_SUB], AFD_OP_UNPACKED_ADJ_DIV}) begin
         e.flg[B_ZR] = ww ? (e.res == 16'h0000) : (e.res[7:0] == 8'h00);
         e.flg[B_SG] = ww ? e.res[15] : e.res[7];
         e.flg[B_PA] = ~^e.res[7:0];
      end
      return e;
   endfunction

   // ----------------------------------------------------------------
   // driving, checking and closing
   // ----------------------------------------------------------------
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_flags(input logic [5:0] got, input logic [5:0] exp);
      check_val({10'h000, got}, {10'h000, exp});
   endtask

   task automatic check_strb(input logic [1:0] got, input logic [1:0] exp);
      check_val({14'h0000, got}, {14'h0000, exp});
   endtask

   task automatic run_op(input afd_op_t o, input logic w, input logic [15:0] d, input logic [15:0] s);
      afd_exp_t e;
      e = model(o, w, d, s, model_flags);
      model_flags = e.flg;
      exp_q.push_back(e);
      u_seq.issue(o, w, d, s);
   endtask

   task automatic test_done();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seen_valid <= 1'b0;
      end else begin
         seen_valid <= op_valid;
      end
   end

   always @(negedge i_sys_clk) begin
      afd_exp_t e;
      if (seen_valid && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e.chk) check_val(o_result, e.res);
         check_strb({o_result_we, o_div_error}, {e.we, e.derr});
         check_flags(flags_out, e.flg);
      end
   end

   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         test_done();
      end
   end

   initial begin
      void'($urandom(32'hABEDB8F5));
      repeat (8) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      check_val(o_result, 16'h0000);
      check_strb({o_result_we, o_div_error}, 2'b00);
      check_flags(flags_out, 6'h00);
      run_op(AFD_OP_ADD, 1'b1, 16'hFFFF, 16'h0001);
      run_op(AFD_OP_ADD_CARRY_IN, 1'b1, 16'h0000, 16'h0000);
      run_op(AFD_OP_ADD, 1'b0, 16'h127F, 16'h0001);
      run_op(AFD_OP_SUBTRACT, 1'b0, 16'h1200, 16'h0001);
      run_op(AFD_OP_SUBTRACT_WITH_BORROW_IN, 1'b1, 16'h0000, 16'h0000);
      run_op(AFD_OP_PLUS_ONE, 1'b1, 16'hFFFF, 16'h0000);
      run_op(AFD_OP_SUBTRACT, 1'b1, 16'h8000, 16'h0001);
      run_op(AFD_OP_MINUS_ONE, 1'b0, 16'h0000, 16'h0000);
      run_op(AFD_OP_SIGN_INVERSION, 1'b0, 16'h0000, 16'h0000);
      run_op(AFD_OP_SIGN_INVERSION, 1'b0, 16'h0080, 16'h0000);
      run_op(AFD_OP_SIGN_INVERSION, 1'b1, 16'h8000, 16'h0000);
      run_op(AFD_OP_SIGN_INVERSION, 1'b1, 16'h0001, 16'h0000);
      run_op(AFD_OP_COMPARE_ONLY, 1'b1, 16'h1234, 16'h1235);
      run_op(AFD_OP_SUBTRACT, 1'b0, 16'h0045, 16'h0038);
      run_op(AFD_OP_PACKED_ADJ_SUB, 1'b0, 16'h000D, 16'h0000);
      run_op(AFD_OP_SUBTRACT, 1'b0, 16'h0003, 16'h0005);
      run_op(AFD_OP_UNPACKED_ADJ_SUB, 1'b0, 16'h01FE, 16'h0000);
      run_op(AFD_OP_ADD, 1'b0, 16'h0038, 16'h0045);
      run_op(AFD_OP_PACKED_ADJ_ADD, 1'b0, 16'h127D, 16'h0000);
      run_op(AFD_OP_ADD, 1'b0, 16'h0099, 16'h0001);
      run_op(AFD_OP_PACKED_ADJ_ADD, 1'b0, 16'h009A, 16'h0000);
      run_op(AFD_OP_ADD, 1'b0, 16'h0038, 16'h0039);
      run_op(AFD_OP_UNPACKED_ADJ_ADD, 1'b0, 16'h0571, 16'h0000);
      run_op(AFD_OP_ADD, 1'b0, 16'h0000, 16'h0000);
      run_op(AFD_OP_UNPACKED_ADJ_ADD, 1'b0, 16'h00F5, 16'h0000);
      run_op(AFD_OP_UNPACKED_ADJ_DIV, 1'b0, 16'h0307, 16'h0000);
      run_op(AFD_OP_UNSIGNED_DIV_BYTE, 1'b0, 16'h0025, 16'h0005);
      run_op(AFD_OP_UNSIGNED_DIV_BYTE, 1'b0, 16'h0100, 16'h0000);
      run_op(AFD_OP_UNSIGNED_DIV_BYTE, 1'b0, 16'h1000, 16'h0002);
      run_op(afd_op_t'(4'hE), 1'b1, 16'h1111, 16'h2222);
      repeat (200) run_op(afd_op_t'(4'($urandom_range(7))), 1'($urandom), 16'($urandom), 16'($urandom));
      u_seq.idle();
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b0;
      model_flags = 6'h00;
      repeat (2) @(negedge i_sys_clk);
      check_flags(flags_out, 6'h00);
      check_val(o_result, 16'h0000);
      check_strb({o_result_we, o_div_error}, 2'b00);
      i_rst_n = 1'b1;
      run_op(AFD_OP_ADD_CARRY_IN, 1'b0, 16'h00FF, 16'h0000);
      u_seq.idle();
      repeat (3) @(negedge i_sys_clk);
      test_done();
   end

endmodule // tb_top
